// ---- tirpa_defines.svh ----
`ifndef TIRPA_DEFINES_SVH
`define TIRPA_DEFINES_SVH

// ----------------------------------------------------------------------
// channel and character layout
// ----------------------------------------------------------------------
`define TIRPA_NUM_CH          4
`define TIRPA_DATA_W          8
`define TIRPA_CTRL_W          2
`define TIRPA_CHAR_W          10
`define TIRPA_BIT_CTRL0       8
`define TIRPA_BIT_CTRL1       9
`define TIRPA_CHAN_A          0

// ----------------------------------------------------------------------
// phase-align buffer geometry and reset values
// ----------------------------------------------------------------------
`define TIRPA_BUF_DEPTH       4
`define TIRPA_PTR_W           2
`define TIRPA_CNT_W           3
`define TIRPA_BUF_FULL        3'h4
`define TIRPA_BUF_EMPTY       3'h0
`define TIRPA_BUF_CENTRE_PTR  2'h2
`define TIRPA_BUF_CENTRE_CNT  3'h2
`define TIRPA_PTR_ZERO        2'h0
`define TIRPA_PTR_ONE         2'h1
`define TIRPA_CNT_ONE         3'h1

`endif

// ---- tirpa_pkg.sv ----
package tirpa_pkg;

`include "tirpa_defines.svh"

// ----------------------------------------------------------------------
// three-level select codes and reset sequencing states
// ----------------------------------------------------------------------
typedef enum logic [1:0] {
	TIRPA_LVL_LOW  = 2'h0,
	TIRPA_LVL_MID  = 2'h1,
	TIRPA_LVL_HIGH = 2'h2
} tirpa_lvl_t;

typedef enum logic [1:0] {
	TIRPA_ST_INIT = 2'h1,
	TIRPA_ST_RUN  = 2'h2
} tirpa_state_t;

// ----------------------------------------------------------------------
// captured character, delivered character, synchronised pins
// ----------------------------------------------------------------------
typedef struct packed {
	logic                      spc_sel;
	logic                      parity;
	logic [`TIRPA_CHAR_W-1:0]  bits;
} tirpa_cap_t;

typedef struct packed {
	logic                      fill;
	logic                      encode;
	logic                      spc_sel;
	logic                      parity;
	logic [`TIRPA_CHAR_W-1:0]  bits;
} tirpa_char_t;

typedef struct packed {
	logic [`TIRPA_NUM_CH-1:0]                     ch_clk;
	logic                                         ref_clk;
	logic                                         trst_n;
	logic                                         drst_n;
	logic [`TIRPA_NUM_CH-1:0][`TIRPA_DATA_W-1:0]  data;
	logic [`TIRPA_NUM_CH-1:0][`TIRPA_CTRL_W-1:0]  ctrl;
	logic [`TIRPA_NUM_CH-1:0]                     par;
	logic                                         spc_sel;
	logic [1:0]                                   mode_hi;
	logic [1:0]                                   mode_lo;
	logic [1:0]                                   cksel;
	logic                                         rate;
} tirpa_pins_t;

endpackage

// ---- tirpa_buffer.sv ----
`timescale 1ns/1ps
`include "tirpa_defines.svh"

module tirpa_buffer (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   init,
	input  wire logic                   wr_en,
	input  wire tirpa_pkg::tirpa_cap_t  wr_data,
	input  wire logic                   rd_en,
	output tirpa_pkg::tirpa_cap_t       rd_data,
	output logic                        err
);

	// ------------------------------------------------------------------
	// storage and pointers
	// ------------------------------------------------------------------
	tirpa_pkg::tirpa_cap_t        mem_reg  [`TIRPA_BUF_DEPTH];
	tirpa_pkg::tirpa_cap_t        mem_next [`TIRPA_BUF_DEPTH];
	logic [`TIRPA_PTR_W-1:0]      wr_ptr_reg;
	logic [`TIRPA_PTR_W-1:0]      wr_ptr_next;
	logic [`TIRPA_PTR_W-1:0]      rd_ptr_reg;
	logic [`TIRPA_PTR_W-1:0]      rd_ptr_next;
	logic [`TIRPA_CNT_W-1:0]      cnt_reg;
	logic [`TIRPA_CNT_W-1:0]      cnt_next;
	logic                         err_reg;
	logic                         err_next;
	logic                         do_wr;
	logic                         do_rd;

	always_comb begin
		mem_next    = mem_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		cnt_next    = cnt_reg;
		err_next    = err_reg;
		do_rd       = rd_en && (cnt_reg != `TIRPA_BUF_EMPTY);
		do_wr       = wr_en && ((cnt_reg != `TIRPA_BUF_FULL) || do_rd);
		if (init) begin
			// pointers half a depth apart, idle characters preloaded
			for (int k = 0; k < `TIRPA_BUF_DEPTH; k++) begin
				mem_next[k] = '0;
			end
			wr_ptr_next = `TIRPA_BUF_CENTRE_PTR;
			rd_ptr_next = `TIRPA_PTR_ZERO;
			cnt_next    = `TIRPA_BUF_CENTRE_CNT;
			err_next    = 1'h0;
		end else begin
			if (do_wr) begin
				mem_next[wr_ptr_reg] = wr_data;
				wr_ptr_next          = wr_ptr_reg + `TIRPA_PTR_ONE;
			end
			if (do_rd) begin
				rd_ptr_next = rd_ptr_reg + `TIRPA_PTR_ONE;
			end
			if (do_wr && !do_rd) begin
				cnt_next = cnt_reg + `TIRPA_CNT_ONE;
			end else if (!do_wr && do_rd) begin
				cnt_next = cnt_reg - `TIRPA_CNT_ONE;
			end
			// drift beyond the margin either way is sticky until init
			if ((wr_en && !do_wr) || (rd_en && !do_rd)) begin
				err_next = 1'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < `TIRPA_BUF_DEPTH; k++) begin
				mem_reg[k] <= '0;
			end
			wr_ptr_reg <= `TIRPA_BUF_CENTRE_PTR;
			rd_ptr_reg <= `TIRPA_PTR_ZERO;
			cnt_reg    <= `TIRPA_BUF_CENTRE_CNT;
			err_reg    <= 1'h0;
		end else begin
			mem_reg    <= mem_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg    <= cnt_next;
			err_reg    <= err_next;
		end
	end

	assign rd_data = mem_reg[rd_ptr_reg];
	assign err     = err_reg;

endmodule // tirpa_buffer

// ---- tirpa_top.sv ----
`timescale 1ns/1ps
`include "tirpa_defines.svh"


module tirpa_top (
	input  wire logic                                         clk,
	input  wire logic                                         rst,
	input  wire logic                                         chan_a_input_clock,
	input  wire logic [`TIRPA_NUM_CH-2:0]                     chan_bcd_input_clock,
	input  wire logic                                         reference_clock,
	input  wire logic                                         tx_path_reset_n,
	input  wire logic                                         device_reset_n,
	input  wire logic [`TIRPA_NUM_CH-1:0][`TIRPA_DATA_W-1:0]  tx_data_in,
	input  wire logic [`TIRPA_NUM_CH-1:0][`TIRPA_CTRL_W-1:0]  tx_ctrl_in,
	input  wire logic [`TIRPA_NUM_CH-1:0]                     tx_odd_parity_in,
	input  wire logic                                         special_char_select,
	input  wire logic [3:0]                                   tx_mode_select,
	input  wire logic [1:0]                                   tx_clock_select,
	input  wire logic                                         tx_rate_select,
	output tirpa_pkg::tirpa_char_t [`TIRPA_NUM_CH-1:0]        tx_char_out,
	output logic                                              tx_char_valid,
	output logic [`TIRPA_NUM_CH-1:0]                          tx_error_flag,
	output logic                                              tx_buf_active
);

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	function automatic logic lvl_is(input logic [1:0] code,
		input tirpa_pkg::tirpa_lvl_t lvl);
		lvl_is = (code == lvl);
	endfunction

	function automatic tirpa_pkg::tirpa_char_t mk_char(
		input tirpa_pkg::tirpa_cap_t cap,
		input logic                  sc,
		input logic                  fill,
		input logic                  enc,
		input logic                  sc_used);
		mk_char.fill   = fill;
		mk_char.encode = enc;
		mk_char.spc_sel = sc_used & sc;
		mk_char.parity = cap.parity;
		mk_char.bits   = cap.bits;
	endfunction

	// ------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------
	tirpa_pkg::tirpa_pins_t  pins_raw;
	tirpa_pkg::tirpa_pins_t  pins_s1_reg;
	tirpa_pkg::tirpa_pins_t  pins_s1_next;
	tirpa_pkg::tirpa_pins_t  pins_s2_reg;
	tirpa_pkg::tirpa_pins_t  pins_s2_next;
	logic [`TIRPA_NUM_CH-1:0] ch_clk_prev_reg;
	logic [`TIRPA_NUM_CH-1:0] ch_clk_prev_next;
	logic                     ref_prev_reg;
	logic                     ref_prev_next;

	always_comb begin
		pins_raw.ch_clk  = {chan_bcd_input_clock, chan_a_input_clock};
		pins_raw.ref_clk = reference_clock;
		pins_raw.trst_n  = tx_path_reset_n;
		pins_raw.drst_n  = device_reset_n;
		pins_raw.data    = tx_data_in;
		pins_raw.ctrl    = tx_ctrl_in;
		pins_raw.par     = tx_odd_parity_in;
		pins_raw.spc_sel = special_char_select;
		pins_raw.mode_hi = tx_mode_select[3:2];
		pins_raw.mode_lo = tx_mode_select[1:0];
		pins_raw.cksel   = tx_clock_select;
		pins_raw.rate    = tx_rate_select;
	end

	always_comb begin
		pins_s1_next     = pins_raw;
		pins_s2_next     = pins_s1_reg;
		ch_clk_prev_next = pins_s2_reg.ch_clk;
		ref_prev_next    = pins_s2_reg.ref_clk;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins_s1_reg     <= '0;
			pins_s2_reg     <= '0;
			ch_clk_prev_reg <= '0;
			ref_prev_reg    <= 1'h0;
		end else begin
			pins_s1_reg     <= pins_s1_next;
			pins_s2_reg     <= pins_s2_next;
			ch_clk_prev_reg <= ch_clk_prev_next;
			ref_prev_reg    <= ref_prev_next;
		end
	end

	// ------------------------------------------------------------------
	// clock edges and mode decode
	// ------------------------------------------------------------------
	logic [`TIRPA_NUM_CH-1:0] ch_rise;
	logic                     ref_rise;
	logic                     ref_fall;
	logic                     bypass;
	logic                     char_stb;
	logic                     encode_on;
	logic                     special_char_select_on;

	always_comb begin
		ch_rise   = pins_s2_reg.ch_clk & ~ch_clk_prev_reg;
		ref_rise  = pins_s2_reg.ref_clk & ~ref_prev_reg;
		ref_fall  = ~pins_s2_reg.ref_clk & ref_prev_reg;
		bypass    = lvl_is(pins_s2_reg.cksel, tirpa_pkg::TIRPA_LVL_LOW)
			&& !pins_s2_reg.rate;
		char_stb  = ref_rise || (pins_s2_reg.rate && ref_fall);
		encode_on = !lvl_is(pins_s2_reg.mode_hi,
			tirpa_pkg::TIRPA_LVL_LOW);
		special_char_select_on  = encode_on && !lvl_is(pins_s2_reg.mode_lo,
			tirpa_pkg::TIRPA_LVL_HIGH);
	end

	// ------------------------------------------------------------------
	// transmit reset sequencing
	// ------------------------------------------------------------------
	tirpa_pkg::tirpa_state_t  state_reg;
	tirpa_pkg::tirpa_state_t  state_next;
	logic                     chan_a_rise;
	logic                     buf_init;

	always_comb begin
		chan_a_rise = ch_rise[`TIRPA_CHAN_A];
		state_next  = state_reg;
		unique case (state_reg)
			tirpa_pkg::TIRPA_ST_INIT: begin
				// release fixes the present input phase as the centre
				if (chan_a_rise && pins_s2_reg.trst_n
					&& pins_s2_reg.drst_n) begin
					state_next = tirpa_pkg::TIRPA_ST_RUN;
				end
			end
			tirpa_pkg::TIRPA_ST_RUN: begin
				if (!pins_s2_reg.drst_n) begin
					state_next = tirpa_pkg::TIRPA_ST_INIT;
				end else if (chan_a_rise && !pins_s2_reg.trst_n) begin
					state_next = tirpa_pkg::TIRPA_ST_INIT;
				end
			end
		endcase
		buf_init = (state_reg == tirpa_pkg::TIRPA_ST_INIT)
			|| !pins_s2_reg.drst_n;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= tirpa_pkg::TIRPA_ST_INIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// input registers and phase-align buffers
	// ------------------------------------------------------------------
	tirpa_pkg::tirpa_cap_t [`TIRPA_NUM_CH-1:0] cap_reg;
	tirpa_pkg::tirpa_cap_t [`TIRPA_NUM_CH-1:0] cap_next;
	logic [`TIRPA_NUM_CH-1:0]                  cap_v_reg;
	logic [`TIRPA_NUM_CH-1:0]                  cap_v_next;
	tirpa_pkg::tirpa_cap_t [`TIRPA_NUM_CH-1:0] rd_data;
	logic [`TIRPA_NUM_CH-1:0]                  buf_err;
	logic                                      rd_en;

	assign rd_en = char_stb && !bypass && !buf_init;

	generate
		for (genvar i = 0; i < `TIRPA_NUM_CH; i++) begin : g_ch
			logic cap_stb;

			always_comb begin
				unique case (pins_s2_reg.cksel)
					tirpa_pkg::TIRPA_LVL_LOW:
						cap_stb = char_stb;
					tirpa_pkg::TIRPA_LVL_MID:
						cap_stb = chan_a_rise;
					default:
						cap_stb = ch_rise[i];
				endcase
				cap_next[i]   = cap_reg[i];
				cap_v_next[i] = cap_stb;
				if (cap_stb) begin
					cap_next[i].bits[`TIRPA_DATA_W-1:0] =
						pins_s2_reg.data[i];
					cap_next[i].bits[`TIRPA_BIT_CTRL0] =
						pins_s2_reg.ctrl[i][0];
					cap_next[i].bits[`TIRPA_BIT_CTRL1] =
						pins_s2_reg.ctrl[i][1];
					cap_next[i].parity = pins_s2_reg.par[i];
					cap_next[i].spc_sel = pins_s2_reg.spc_sel;
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cap_reg[i]   <= '0;
					cap_v_reg[i] <= 1'h0;
				end else begin
					cap_reg[i]   <= cap_next[i];
					cap_v_reg[i] <= cap_v_next[i];
				end
			end

			tirpa_buffer u_buf (
				.clk     (clk),
				.rst     (rst),
				.init    (buf_init),
				.wr_en   (cap_v_reg[i] && !bypass && !buf_init),
				.wr_data (cap_reg[i]),
				.rd_en   (rd_en),
				.rd_data (rd_data[i]),
				.err     (buf_err[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// character output stage
	// ------------------------------------------------------------------
	tirpa_pkg::tirpa_char_t [`TIRPA_NUM_CH-1:0] out_reg;
	tirpa_pkg::tirpa_char_t [`TIRPA_NUM_CH-1:0] out_next;
	logic                                       out_v_reg;
	logic                                       out_v_next;
	logic [`TIRPA_NUM_CH-1:0]                   err_reg;
	logic [`TIRPA_NUM_CH-1:0]                   err_next;
	logic                                       active_reg;
	logic                                       active_next;
	logic                                       sc_common;

	always_comb begin
		out_next    = out_reg;
		out_v_next  = 1'h0;
		active_next = !bypass;
		// channel A's select governs every channel of the cycle
		sc_common   = bypass ? cap_reg[`TIRPA_CHAN_A].spc_sel
			: rd_data[`TIRPA_CHAN_A].spc_sel;
		for (int i = 0; i < `TIRPA_NUM_CH; i++) begin
			err_next[i] = !bypass && buf_err[i];
			if (bypass && cap_v_reg[`TIRPA_CHAN_A]) begin
				out_next[i] = mk_char(cap_reg[i], sc_common, 1'h0,
					encode_on, special_char_select_on);
			end else if (rd_en) begin
				out_next[i] = mk_char(rd_data[i], sc_common, buf_err[i],
					encode_on, special_char_select_on);
			end
		end
		if (bypass) begin
			out_v_next = cap_v_reg[`TIRPA_CHAN_A];
		end else begin
			out_v_next = rd_en;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_reg    <= '0;
			out_v_reg  <= 1'h0;
			err_reg    <= '0;
			active_reg <= 1'h0;
		end else begin
			out_reg    <= out_next;
			out_v_reg  <= out_v_next;
			err_reg    <= err_next;
			active_reg <= active_next;
		end
	end

	assign tx_char_out   = out_reg;
	assign tx_char_valid = out_v_reg;
	assign tx_error_flag = err_reg;
	assign tx_buf_active = active_reg;

endmodule // tirpa_top

// ---- tirpa_top_chk.sv ----
`timescale 1ns/1ps
`include "tirpa_defines.svh"

module tirpa_top_chk (
	input wire logic                                   clk,
	input wire logic                                   rst,
	input wire logic                                   reference_clock,
	input wire logic                                   tx_path_reset_n,
	input wire logic                                   device_reset_n,
	input wire logic [3:0]                             tx_mode_select,
	input wire logic [1:0]                             tx_clock_select,
	input wire logic                                   tx_rate_select,
	input wire tirpa_pkg::tirpa_char_t [`TIRPA_NUM_CH-1:0] tx_char_out,
	input wire logic                                   tx_char_valid,
	input wire logic [`TIRPA_NUM_CH-1:0]               tx_error_flag,
	input wire logic                                   tx_buf_active
);
	logic [`TIRPA_NUM_CH-1:0] fill_vec;
	logic [`TIRPA_NUM_CH-1:0] enc_vec;
	logic [`TIRPA_NUM_CH-1:0] sc_vec;
	logic [3:0]               hi_cnt_reg;
	logic [3:0]               hi_cnt_next;

	always_comb begin
		for (int i = 0; i < `TIRPA_NUM_CH; i++) begin
			fill_vec[i] = tx_char_out[i].fill;
			enc_vec[i]  = tx_char_out[i].encode;
			sc_vec[i]   = tx_char_out[i].spc_sel;
		end
	end

	// cycles since either reset was last seen low, saturating at 15
	always_comb begin
		hi_cnt_next = hi_cnt_reg;
		if (!(tx_path_reset_n && device_reset_n))
			hi_cnt_next = 4'h0;
		else if (hi_cnt_reg != 4'hF)
			hi_cnt_next = hi_cnt_reg + 4'h1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			hi_cnt_reg <= 4'h0;
		else
			hi_cnt_reg <= hi_cnt_next;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_valid_gap: assert property (tx_char_valid |=> !tx_char_valid [*3])
		else $error("character valid closer than four cycles");
	a_bypass_path: assert property (
		(tx_clock_select == 2'h0 && !tx_rate_select) [*4]
		|-> !tx_buf_active)
		else $error("buffer path used in bypass configuration");
	a_buffer_path: assert property (
		(tx_clock_select != 2'h0 || tx_rate_select) [*4]
		|-> tx_buf_active)
		else $error("buffer path not used when required");
	a_bypass_no_err: assert property (
		!tx_buf_active [*3] |-> tx_error_flag == 4'h0)
		else $error("error flag raised in bypass");
	a_err_sticky: assert property (
		hi_cnt_reg >= 4'h8 && tx_buf_active && $past(tx_buf_active)
		|-> (tx_error_flag & $past(tx_error_flag))
		== $past(tx_error_flag))
		else $error("error flag cleared without buffer init");
	a_err_fill: assert property (
		tx_char_valid && tx_buf_active
		|-> (tx_error_flag & $past(tx_error_flag) & ~fill_vec) == 4'h0)
		else $error("errored channel not sending fill");
	a_init_quiet: assert property (
		(!device_reset_n) [*6] |-> !(tx_char_valid && tx_buf_active))
		else $error("buffer delivered a character during init");
	a_encode_flag: assert property (
		(!tx_buf_active && $stable(tx_mode_select)) [*8]
		##0 tx_char_valid
		|-> enc_vec == {4{tx_mode_select[3:2] != 2'h0}})
		else $error("encode mark does not follow upper mode select");
	a_spc_same: assert property (
		tx_char_valid |-> sc_vec == {4{sc_vec[0]}})
		else $error("special select differs between channels");
	a_spc_mask: assert property (
		(!tx_buf_active && $stable(tx_mode_select)) [*8]
		##0 tx_char_valid && (tx_mode_select[1:0] == 2'h2
		|| tx_mode_select[3:2] == 2'h0) |-> sc_vec == 4'h0)
		else $error("special select passed while masked");
	a_bypass_latency: assert property (
		(!tx_buf_active && device_reset_n) [*4]
		##0 $rose(reference_clock) |-> ##[2:7] tx_char_valid)
		else $error("bypass character late or missing");

	c_buf_char: cover property (tx_char_valid && tx_buf_active);
	c_byp_char: cover property (tx_char_valid && !tx_buf_active);
	c_error: cover property (|tx_error_flag);
endmodule // tirpa_top_chk

bind tirpa_top tirpa_top_chk i_chk (
	.clk(clk), .rst(rst), .reference_clock(reference_clock),
	.tx_path_reset_n(tx_path_reset_n), .device_reset_n(device_reset_n),
	.tx_mode_select(tx_mode_select), .tx_clock_select(tx_clock_select),
	.tx_rate_select(tx_rate_select), .tx_char_out(tx_char_out),
	.tx_char_valid(tx_char_valid), .tx_error_flag(tx_error_flag),
	.tx_buf_active(tx_buf_active)
);

// ---- tirpa_host.sv ----
`timescale 1ns/1ps
`include "tirpa_defines.svh"

module tirpa_host (
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire logic                                  rst_req,
	input  wire logic [1:0]                            cksel,
	input  wire logic                                  ref_clk,
	input  wire logic                                  clk_a,
	input  wire logic [`TIRPA_NUM_CH-2:0]              clk_bcd,
	output logic [`TIRPA_NUM_CH-1:0][`TIRPA_DATA_W-1:0] data,
	output logic [`TIRPA_NUM_CH-1:0][`TIRPA_CTRL_W-1:0] ctrl,
	output logic [`TIRPA_NUM_CH-1:0]                   par,
	output logic                                       spc_sel,
	output logic                                       trst_n
);
	logic [`TIRPA_NUM_CH-1:0] sel;
	logic [`TIRPA_NUM_CH-1:0] own_clk;
	logic [`TIRPA_NUM_CH-1:0] prev;
	logic [1:0]               rises;
	logic                     a_q;

	always_comb begin
		own_clk = {clk_bcd, clk_a};
		for (int i = 0; i < `TIRPA_NUM_CH; i++) begin
			sel[i]  = (cksel == 2'h0) ? ref_clk :
				(cksel == 2'h1) ? clk_a : own_clk[i];
			ctrl[i] = data[i][1:0] ^ 2'(i);
			par[i]  = ~^{data[i], ctrl[i]};
		end
		spc_sel = data[0][0];
	end

	// new character after each falling edge of the clock picked by cksel (reference, channel A or the channel's own)
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			data   <= '0;
			prev   <= 4'h0;
			rises  <= 2'h0;
			a_q    <= 1'h0;
			trst_n <= 1'h1;
		end else begin
			a_q  <= clk_a;
			prev <= sel;
			for (int i = 0; i < `TIRPA_NUM_CH; i++)
				if (prev[i] && !sel[i])
					data[i] <= data[i] + 8'h01;
			if (rst_req) begin
				trst_n <= 1'h0;
				rises  <= 2'h0;
			end else if (!trst_n && clk_a && !a_q) begin
				rises <= rises + 2'h1;
				if (rises == 2'h2)
					trst_n <= 1'h1;
			end
		end
	end
endmodule // tirpa_host

// ---- tirpa_tb.sv ----
`timescale 1ns/1ps
`include "tirpa_defines.svh"

module tirpa_tb;
	typedef struct packed {
		logic [1:0] ck;
		logic       rt;
		logic [3:0] md;
		logic       act;
		logic       dchk;
	} tirpa_row_t;

	localparam tirpa_row_t ROWS [7] = '{
		'{2'h0, 1'h0, 4'h0, 1'h0, 1'h1}, '{2'h0, 1'h0, 4'h4, 1'h0, 1'h1},
		'{2'h0, 1'h0, 4'hA, 1'h0, 1'h1}, '{2'h1, 1'h0, 4'h5, 1'h1, 1'h1},
		'{2'h2, 1'h0, 4'h8, 1'h1, 1'h1}, '{2'h3, 1'h0, 4'h6, 1'h1, 1'h1},
		'{2'h0, 1'h1, 4'h9, 1'h1, 1'h0}};

	logic                                      clk = 1'h0;
	logic                                      rst = 1'h1;
	logic                                      ref_clk = 1'h0;
	logic                                      a_clk = 1'h0;
	logic [2:0]                                bcd = 3'h0;
	logic                                      rst_req = 1'h0;
	logic                                      dev_rst_n = 1'h1;
	logic [3:0]                                mode = 4'h0;
	logic [1:0]                                cksel = 2'h0;
	logic                                      rate = 1'h0;
	logic                                      trst_n;
	logic [`TIRPA_NUM_CH-1:0][`TIRPA_DATA_W-1:0] data;
	logic [`TIRPA_NUM_CH-1:0][`TIRPA_CTRL_W-1:0] ctrl;
	logic [`TIRPA_NUM_CH-1:0]                  par;
	logic                                      spc_sel;
	tirpa_pkg::tirpa_char_t [`TIRPA_NUM_CH-1:0] chr;
	logic                                      valid;
	logic [`TIRPA_NUM_CH-1:0]                  err;
	logic                                      active;
	logic [7:0]                                prev [4];
	logic [3:0]                                have_prev = 4'h0;
	logic                                      chk_on = 1'h0;
	int                                        n_valid = 0;
	int                                        n_errors = 0;
	int                                        n_checks = 0;
	real                                       b_half = 100.0;

	always #12.5 clk = ~clk;
	always #100 ref_clk = ~ref_clk;
	initial begin #30; forever #100 a_clk = ~a_clk; end
	initial begin #70; forever #(b_half) bcd[0] = ~bcd[0]; end
	initial begin #45; forever #100 bcd[1] = ~bcd[1]; end
	initial begin #150; forever #100 bcd[2] = ~bcd[2]; end

	tirpa_top i_dut (.clk(clk), .rst(rst), .chan_a_input_clock(a_clk),
		.chan_bcd_input_clock(bcd), .reference_clock(ref_clk),
		.tx_path_reset_n(trst_n), .device_reset_n(dev_rst_n), .tx_data_in(data),
		.tx_ctrl_in(ctrl), .tx_odd_parity_in(par),
		.special_char_select(spc_sel),
		.tx_mode_select(mode), .tx_clock_select(cksel), .tx_rate_select(rate),
		.tx_char_out(chr), .tx_char_valid(valid), .tx_error_flag(err),
		.tx_buf_active(active));

	tirpa_host i_host (.clk(clk), .rst(rst), .rst_req(rst_req), .cksel(cksel),
		.ref_clk(ref_clk), .clk_a(a_clk), .clk_bcd(bcd), .data(data), .ctrl(ctrl),
		.par(par), .spc_sel(spc_sel), .trst_n(trst_n));

	task automatic check(string what, logic [15:0] seen_v, logic [15:0] exp_v);
		n_checks++;
		if (seen_v !== exp_v) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp_v, seen_v);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wait_clk(int n);
		repeat (n) @(negedge clk);
	endtask

	// ------------------------------------------------------------------
	// monitor: per-channel counting stream, zero characters restart it
	// ------------------------------------------------------------------
	always @(negedge clk) begin
		if (valid === 1'h1) begin
			n_valid++;
			for (int i = 0; i < 4; i++) begin
				if (!chk_on || chr[i].bits == 10'h0) begin
					have_prev[i] = 1'h0;
				end else begin
					if (have_prev[i])
						check("data", 16'(chr[i].bits[7:0]),
							16'(8'(prev[i] + 8'h01)));
					check("ctrl", 16'(chr[i].bits[9:8]),
						16'(chr[i].bits[1:0] ^ 2'(i)));
					check("parity", 16'(chr[i].parity),
						16'(~^chr[i].bits));
					check("encode", 16'(chr[i].encode),
						16'(mode[3:2] != 2'h0));
					check("special", 16'(chr[i].spc_sel), 16'(chr[0].bits[0]
						& (mode[3:2] != 2'h0) & (mode[1:0] != 2'h2)));
					prev[i] = chr[i].bits[7:0];
					have_prev[i] = 1'h1;
				end
			end
		end
	end

	task automatic tx_reset();
		@(negedge clk) rst_req <= 1'h1;
		@(negedge clk) rst_req <= 1'h0;
		wait_clk(60);
	endtask

	task automatic run_row(tirpa_row_t r);
		@(negedge clk);
		chk_on = 1'h0;
		cksel = r.ck;
		rate = r.rt;
		mode = r.md;
		tx_reset();
		chk_on = r.dchk;
		n_valid = 0;
		wait_clk(400);
		check("count", 16'(r.rt ? (n_valid >= 95 && n_valid <= 101)
			: (n_valid >= 48 && n_valid <= 51)), 16'h0001);
		check("active", 16'(active), 16'(r.act));
		check("error", 16'(err), 16'h0000);
	endtask

	initial begin
		#250000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		wait_clk(2);
		rst = 1'h0;
		@(negedge clk);
		check("after reset", 16'({valid, err, active}), 16'h0000);
		foreach (ROWS[k])
			run_row(ROWS[k]);
		// channel B faster than the reference: buffer overruns
		run_row('{2'h2, 1'h0, 4'h5, 1'h1, 1'h1});
		chk_on = 1'h0;
		b_half = 80.0;
		wait_clk(800);
		check("overrun flag", 16'(err), 16'h0002);
		n_valid = 0;
		for (int t = 0; t < 20 && n_valid == 0; t++)
			@(negedge clk);
		check("fill", 16'({chr[1].fill, chr[0].fill}), 16'h0002);
		b_half = 100.0;
		tx_reset();
		check("flag cleared", 16'(err), 16'h0000);
		chk_on = 1'h1;
		wait_clk(300);
		check("recentred", 16'(err), 16'h0000);
		// device reset holds the buffers in init
		run_row(ROWS[3]);
		dev_rst_n = 1'h0;
		wait_clk(8);
		n_valid = 0;
		wait_clk(40);
		check("init quiet", 16'(n_valid), 16'h0000);
		dev_rst_n = 1'h1;
		tx_reset();
		n_valid = 0;
		wait_clk(200);
		check("resumed", 16'(n_valid >= 20), 16'h0001);
		rst = 1'h1;
		@(negedge clk);
		check("mid reset", 16'({valid, err, active}), 16'h0000);
		rst = 1'h0;
		report_and_stop();
	end
endmodule // tirpa_tb
